/* File: mnnod_decoder.sv */
// Operation
// - prefix 09 marks destination indirect
// - prefix 41 marks source indirect
// - prefix 49 marks both operands indirect
// - shared five-bit register and indirect codes
// - one indirect: one byte, three cycles more
// - both indirect: one byte, six cycles more
// - word immediate adds two immediate bytes
// - long multiply refuses any indirect prefix
// - long multiply eight or nine cycles
// - general multiply three, five, six cycles
// - short OR two-bit destination, one/three cycles
// - immediate OR one or three cycles
// - general OR one, three, four cycles
module mnnod_decoder #(
  parameter int EXT_BYTES = 6
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     fetch_valid,
  input  wire logic               [7:0] fetch_byte,
  output logic                          fetch_ready,
  output logic                          dec_valid,
  output mnnod_pkg::mnnod_info_type     dec_info,
  output logic      [8*EXT_BYTES-1:0]   ext_bytes,
  output logic                          exec_busy
);
  import mnnod_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] short_dest(input logic [1:0] f);
    case (f)
      SHORT_REG:   short_dest = MODE_REG0;
      SHORT_ABS16: short_dest = MODE_ABS16;
      SHORT_SB:    short_dest = MODE_SB_D8;
      default:     short_dest = MODE_FB_D8;
    endcase
  endfunction : short_dest

  function automatic logic [1:0] op_bytes(input logic [3:0] c);
    case (c)
      CLS_UMUL_IMM, CLS_UMUL_GEN, CLS_NEGATE,
      CLS_INVERT, CLS_OR_IMM, CLS_OR_GEN: op_bytes = OPB_TWO;
      CLS_UMUL_LONG:                      op_bytes = OPB_LONG;
      default:                            op_bytes = OPB_ONE;
    endcase
  endfunction : op_bytes

  function automatic logic [3:0] base_cycles(input logic [3:0] c, input logic sm, input logic dm);
    case (c)
      CLS_UMUL_IMM:  base_cycles = dm ? CYC_UMUL_RM : CYC_UMUL_RR;
      CLS_UMUL_GEN:  base_cycles = (sm && dm) ? CYC_UMUL_MM : (sm || dm) ? CYC_UMUL_RM : CYC_UMUL_RR;
      CLS_UMUL_LONG: base_cycles = sm ? CYC_LONG_M : CYC_LONG_R;
      CLS_OR_GEN:    base_cycles = (sm && dm) ? CYC_OR_MM : (sm || dm) ? CYC_OR_RM : CYC_OR_RR;
      CLS_OR_IMM:    base_cycles = dm ? CYC_OR_RM : CYC_OR_RR;
      CLS_OR_SHORT:  base_cycles = dm ? CYC_OR_RM : CYC_OR_RR;
      CLS_NEGATE,
      CLS_INVERT:    base_cycles = dm ? CYC_UN_M : CYC_UN_R;
      default:       base_cycles = CYC_NOP;
    endcase
  endfunction : base_cycles

  ////////////////////////////////////////////////////////////////////////////
  mnnod_state_type state_r;
  mnnod_state_type state_nxt;
  mnnod_info_type  pend_r;
  mnnod_info_type  info_now;
  mnnod_opnd_type  src_op;
  mnnod_opnd_type  dst_op;
  logic            pre_src_r;
  logic            pre_dst_r;
  logic      [7:0] byte0_r;
  logic      [7:0] byte1_r;
  logic      [2:0] ext_left_r;
  logic            timer_done;

  wire accept  = fetch_valid && fetch_ready;
  wire in_op   = state_r == S_OP;
  wire in_op1  = state_r == S_OP1;
  wire in_op2  = state_r == S_OP2;
  wire in_ext  = state_r == S_EXT;
  wire pre_any = pre_src_r || pre_dst_r;
  // a second prefix byte is taken as an opcode and decodes as illegal
  wire is_pfx  = in_op && !pre_any && (fetch_byte == PFX_DST || fetch_byte == PFX_SRC || fetch_byte == PFX_BOTH);

  ////////////////////////////////////////////////////////////////////////////
  // decode straight from the byte in flight so no cycle is lost
  wire [7:0] w0        = in_op ? fetch_byte : byte0_r;
  wire [7:0] w1        = in_op1 ? fetch_byte : byte1_r;
  wire [3:0] cls       = w0[7:4];
  wire       size      = w0[3];
  wire       long_form = cls == CLS_UMUL_LONG;
  wire       short_or  = cls == CLS_OR_SHORT;
  wire       two_op    = cls == CLS_UMUL_GEN || cls == CLS_OR_GEN;
  wire       imm_form  = cls == CLS_UMUL_IMM || cls == CLS_OR_IMM || short_or;
  wire       has_src   = two_op || long_form;
  wire       has_dst   = !long_form && cls != CLS_NOP;
  wire       known     = cls == CLS_UMUL_IMM || cls == CLS_UMUL_GEN || long_form || cls == CLS_NEGATE ||
                         cls == CLS_INVERT || cls == CLS_NOP || cls == CLS_OR_IMM || short_or || two_op;
  wire [4:0] src_code  = {w0[2:0], w1[7:6]};
  wire [4:0] dst_code  = short_or ? short_dest(w0[1:0]) : w1[5:1];

  mnnod_operand u_src (
    .code      (src_code),
    .size      (size),
    .long_form (long_form),
    .opnd      (src_op)
  );

  mnnod_operand u_dst (
    .code      (dst_code),
    .size      (size),
    .long_form (1'b0),
    .opnd      (dst_op)
  );

  wire       src_mem  = has_src && src_op.mem;
  wire       dst_mem  = has_dst && dst_op.mem;
  wire [1:0] src_nb   = has_src ? src_op.nbytes : 2'h0;
  wire [1:0] dst_nb   = has_dst ? dst_op.nbytes : 2'h0;
  wire [1:0] imm_nb   = !imm_form ? 2'h0 : size ? IMM_WORD : IMM_BYTE;
  wire [2:0] ext_all  = {1'b0, src_nb} + {1'b0, dst_nb} + {1'b0, imm_nb};
  wire [3:0] base_len = {2'b00, op_bytes(cls)} + {1'b0, ext_all};
  wire [3:0] base_cyc = base_cycles(cls, src_mem, dst_mem);
  wire [3:0] add_cyc  = (pre_src_r && pre_dst_r) ? CYC_IND_BOTH : pre_any ? CYC_IND_ONE : 4'h0;
  wire       bad_pfx  = (pre_dst_r && !has_dst) || (pre_src_r && !two_op);
  wire       bad_dst  = (cls == CLS_UMUL_IMM || cls == CLS_UMUL_GEN) && size && dst_mem;
  wire       illegal  = !known || bad_pfx || bad_dst || (has_src && src_op.bad) || (has_dst && dst_op.bad);
  wire [2:0] ext_now  = illegal ? 3'h0 : ext_all;

  always_comb begin
    info_now          = '0;
    info_now.cls      = cls;
    info_now.size     = size;
    info_now.src_code = src_code;
    info_now.dst_code = dst_code;
    info_now.src      = src_op;
    info_now.dst      = dst_op;
    info_now.ind_src  = pre_src_r;
    info_now.ind_dst  = pre_dst_r;
    info_now.base_len = base_len;
    info_now.base_cyc = base_cyc;
    info_now.len      = base_len + (pre_any ? LEN_PREFIX : 4'h0);
    info_now.cyc      = illegal ? CYC_ILLEGAL : base_cyc + add_cyc;
    info_now.illegal  = illegal;
  end

  ////////////////////////////////////////////////////////////////////////////
  wire op_done    = accept && ((in_op && !is_pfx && op_bytes(cls) == OPB_ONE) ||
                               (in_op1 && !long_form) || in_op2);
  wire finish_now = (op_done && ext_now == 3'h0) || (in_ext && accept && ext_left_r == 3'h1);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_OP: begin
        if (accept && !is_pfx) begin
          state_nxt = finish_now ? S_EXEC : op_done ? S_EXT : S_OP1;
        end
      end
      S_OP1: begin
        if (accept) begin
          state_nxt = long_form ? S_OP2 : finish_now ? S_EXEC : S_EXT;
        end
      end
      S_OP2: begin
        if (accept) begin
          state_nxt = finish_now ? S_EXEC : S_EXT;
        end
      end
      S_EXT: begin
        if (finish_now) begin
          state_nxt = S_EXEC;
        end
      end
      S_EXEC: begin
        if (timer_done) begin
          state_nxt = S_OP;
        end
      end
      default: state_nxt = S_OP;
    endcase
  end

  mnnod_timer #(.WIDTH(4)) u_timer (
    .clock (clock),
    .rst   (rst),
    .load  (finish_now),
    .count (op_done ? info_now.cyc : pend_r.cyc),
    .busy  (exec_busy),
    .done  (timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r     <= S_OP;
      fetch_ready <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      fetch_ready <= state_nxt != S_EXEC; // fetch stalls while executing
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre_src_r <= 1'b0;
      pre_dst_r <= 1'b0;
    end else if (accept && is_pfx) begin
      pre_src_r <= fetch_byte != PFX_DST;
      pre_dst_r <= fetch_byte != PFX_SRC;
    end else if (finish_now) begin
      pre_src_r <= 1'b0;
      pre_dst_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      byte0_r <= 8'h00;
      byte1_r <= 8'h00;
    end else begin
      byte0_r <= (accept && in_op && !is_pfx) ? fetch_byte : byte0_r;
      byte1_r <= (accept && in_op1) ? fetch_byte : byte1_r;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_r     <= '0;
      ext_left_r <= 3'h0;
      ext_bytes  <= '0;
    end else if (op_done) begin
      pend_r     <= info_now;
      ext_left_r <= ext_now;
      ext_bytes  <= '0;
    end else if (in_ext && accept) begin
      ext_left_r <= ext_left_r - 3'h1;
      ext_bytes  <= {ext_bytes[8*EXT_BYTES-9:0], fetch_byte};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dec_valid <= 1'b0;
      dec_info  <= '0;
    end else begin
      dec_valid <= finish_now;
      dec_info  <= finish_now ? (op_done ? info_now : pend_r) : dec_info;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  wire dv = dec_valid && !dec_info.illegal;

  a_prefix_dst: assert property (accept && is_pfx && fetch_byte == PFX_DST |=> pre_dst_r && !pre_src_r)
    else $error("dest prefix not recorded");
  a_prefix_src: assert property (accept && is_pfx && fetch_byte == PFX_SRC |=> pre_src_r && !pre_dst_r)
    else $error("source prefix not recorded");
  a_prefix_both: assert property (accept && is_pfx && fetch_byte == PFX_BOTH |=> pre_src_r && pre_dst_r)
    else $error("double prefix not recorded");
  a_areg_code: assert property (dv && dec_info.dst.kind == K_AREG |-> dec_info.dst_code[4:1] == MODE_AREG)
    else $error("address register code mismatch");
  a_disp_width: assert property (dv && dec_info.dst_code[4:2] == MODE_D16 |-> dec_info.dst.nbytes == NB_16)
    else $error("16-bit displacement width wrong");
  a_one_indirect: assert property (dv && (dec_info.ind_src ^ dec_info.ind_dst) |->
    dec_info.cyc == dec_info.base_cyc + CYC_IND_ONE && dec_info.len == dec_info.base_len + LEN_PREFIX)
    else $error("single indirect cost wrong");
  a_both_indirect: assert property (dv && dec_info.ind_src && dec_info.ind_dst |->
    dec_info.cyc == dec_info.base_cyc + CYC_IND_BOTH && dec_info.len == dec_info.base_len + LEN_PREFIX)
    else $error("double indirect cost wrong");
  a_word_imm: assert property (dv && dec_info.cls == CLS_UMUL_IMM && dec_info.size && !dec_info.ind_dst |->
    dec_info.len == {2'b00, OPB_TWO} + {2'b00, IMM_WORD} + {2'b00, dec_info.dst.nbytes})
    else $error("word immediate length wrong");
  a_long_prefix: assert property (dec_valid && dec_info.cls == CLS_UMUL_LONG &&
    (dec_info.ind_src || dec_info.ind_dst) |-> dec_info.illegal)
    else $error("long multiply accepted a prefix");
  a_long_cycles: assert property (dv && dec_info.cls == CLS_UMUL_LONG |->
    dec_info.cyc == (dec_info.src.mem ? CYC_LONG_M : CYC_LONG_R))
    else $error("long multiply cycles wrong");
  a_umul_busy: assert property (dv && dec_info.cls == CLS_UMUL_GEN && dec_info.cyc == CYC_UMUL_RR |->
    exec_busy [*3] ##1 (!exec_busy && fetch_ready))
    else $error("register multiply busy span wrong");
  a_word_regs: assert property (dv && dec_info.dst.kind == K_REG && dec_info.cls != CLS_UMUL_LONG |->
    dec_info.dst.reg_id[3:2] == (dec_info.size ? REG_WORD0[3:2] : 2'b00))
    else $error("size bit register choice wrong");
  a_nop_cost: assert property (dv && dec_info.cls == CLS_NOP |->
    dec_info.len == {2'b00, OPB_ONE} && dec_info.cyc == CYC_NOP)
    else $error("nop cost wrong");
  a_short_or: assert property (dv && dec_info.cls == CLS_OR_SHORT && !dec_info.ind_dst |->
    dec_info.cyc == (dec_info.dst.mem ? CYC_OR_RM : CYC_OR_RR))
    else $error("short OR cycles wrong");
  a_or_imm: assert property (dv && dec_info.cls == CLS_OR_IMM && !dec_info.ind_dst |->
    dec_info.cyc == (dec_info.dst.mem ? CYC_OR_RM : CYC_OR_RR))
    else $error("immediate OR cycles wrong");
  a_or_general: assert property (dv && dec_info.cls == CLS_OR_GEN &&
    !dec_info.ind_src && !dec_info.ind_dst |-> dec_info.cyc == ((dec_info.src.mem && dec_info.dst.mem) ? CYC_OR_MM
    : (dec_info.src.mem || dec_info.dst.mem) ? CYC_OR_RM : CYC_OR_RR))
    else $error("general OR cycles wrong");

endmodule : mnnod_decoder

/* File: mnnod_decoder_bench.sv */
module mnnod_decoder_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import mnnod_pkg::*;

  logic           clock = 1'b0;
  logic           rst   = 1'b1;
  logic           fetch_valid;
  logic           fetch_ready;
  logic           dec_valid;
  logic           exec_busy;
  logic     [7:0] fetch_byte;
  logic    [47:0] ext_bytes;
  mnnod_info_type dec_info;
  int             num_errors = 0;
  int             compares   = 0;

  initial forever #2.5 clock = ~clock;

  mnnod_decoder dut_u (.clock(clock), .rst(rst), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
    .fetch_ready(fetch_ready), .dec_valid(dec_valid), .dec_info(dec_info), .ext_bytes(ext_bytes),
    .exec_busy(exec_busy));

  mnnod_fetch_model fm_u (.clock(clock), .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] enc(input logic [3:0] c, input logic s, input logic [4:0] sc,
                                      input logic [4:0] dc);
    return {c, s, sc, dc, 1'b0};
  endfunction : enc

  // ext bytes follow a counting pattern so stream order shows up
  task automatic run(input logic [7:0] pre, input logic [15:0] op, input int nop, input int nx,
                     input logic [3:0] xl, input logic [3:0] xc, input logic xi = 1'b0);
    int n;
    if (pre !== 8'h00) fm_u.queue_q.push_back(pre);
    fm_u.queue_q.push_back(op[15:8]);
    if (nop > 1) fm_u.queue_q.push_back(op[7:0]);
    if (nop > 2) fm_u.queue_q.push_back(8'h00);
    for (int i = 0; i < nx; i++) fm_u.queue_q.push_back(8'hc0 + 8'(i));
    n = 0;
    while (dec_valid !== 1'b1 && n < 200) begin
      @(negedge clock);
      #1;
      n++;
    end
    if (n >= 200) begin
      num_errors++;
      stop_test();
    end else begin
      chk(16'(dec_info.illegal), 16'(xi));
      chk(16'(dec_info.cyc), 16'(xc));
      if (!xi) begin
        chk(16'(dec_info.len), 16'(xl));
        chk(16'(fm_u.queue_q.size()), 16'h0000);
        if (nx > 0) chk(16'(ext_bytes[7:0]), 16'(8'hc0 + 8'(nx - 1)));
      end else begin
        // refused forms leave their tail unread
        fm_u.queue_q.delete();
      end
      n = 0;
      while (exec_busy === 1'b1 && n < 20) begin
        chk(16'(fetch_ready), 16'h0000);
        @(negedge clock);
        #1;
        n++;
      end
      chk(16'(n), 16'(xc));
      if (n >= 20) stop_test();
      chk(16'(fetch_ready), 16'h0001);
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_plain();
    run(8'h00, 16'h7000, 1, 0, 4'h1, 4'h1);
    run(8'h00, enc(CLS_INVERT, 1'b1, 5'h12, 5'h10), 2, 0, 4'h2, 4'h1);
    chk(16'(dec_info.dst.reg_id), 16'h0006);
    run(8'h00, enc(CLS_INVERT, 1'b0, 5'h12, 5'h10), 2, 0, 4'h2, 4'h1);
    chk(16'(dec_info.dst.reg_id), 16'h0002);
    run(8'h00, enc(CLS_NEGATE, 1'b1, 5'h12, 5'h02), 2, 0, 4'h2, 4'h1);
    chk(16'(dec_info.dst.reg_id), 16'h000a);
    run(8'h00, enc(CLS_NEGATE, 1'b0, 5'h12, 5'h0e), 2, 3, 4'h5, 4'h3);
    $display("test plain done");
  endtask : t_plain

  task automatic t_umul();
    run(8'h00, enc(CLS_UMUL_GEN, 1'b0, 5'h12, 5'h12), 2, 0, 4'h2, 4'h3);
    run(8'h00, enc(CLS_UMUL_GEN, 1'b0, 5'h04, 5'h04), 2, 2, 4'h4, 4'h6);
    run(8'h00, enc(CLS_UMUL_GEN, 1'b0, 5'h0c, 5'h0e), 2, 6, 4'h8, 4'h6);
    run(8'h00, enc(CLS_UMUL_IMM, 1'b0, 5'h12, 5'h12), 2, 1, 4'h3, 4'h3);
    run(8'h00, enc(CLS_UMUL_IMM, 1'b1, 5'h12, 5'h12), 2, 2, 4'h4, 4'h3);
    run(8'h00, enc(CLS_UMUL_IMM, 1'b1, 5'h12, 5'h06), 2, 0, 4'h0, 4'h1, 1'b1);
    $display("test umul done");
  endtask : t_umul

  task automatic t_long();
    run(8'h00, enc(CLS_UMUL_LONG, 1'b0, 5'h12, 5'h00), 3, 0, 4'h3, 4'h8);
    run(8'h00, enc(CLS_UMUL_LONG, 1'b0, 5'h0f, 5'h00), 3, 2, 4'h5, 4'h9);
    run(PFX_DST, enc(CLS_UMUL_LONG, 1'b0, 5'h12, 5'h00), 3, 0, 4'h0, 4'h1, 1'b1);
    $display("test long done");
  endtask : t_long

  task automatic t_prefix();
    run(PFX_DST, enc(CLS_NEGATE, 1'b0, 5'h12, 5'h04), 2, 1, 4'h4, 4'h6);
    chk(16'({dec_info.ind_src, dec_info.ind_dst}), 16'h0001);
    run(PFX_SRC, enc(CLS_UMUL_GEN, 1'b0, 5'h00, 5'h12), 2, 0, 4'h3, 4'h8);
    chk(16'({dec_info.ind_src, dec_info.ind_dst}), 16'h0002);
    // slow fetch side for this one
    fm_u.gap = 2;
    run(PFX_BOTH, enc(CLS_OR_GEN, 1'b0, 5'h00, 5'h00), 2, 0, 4'h3, 4'ha);
    chk(16'({dec_info.ind_src, dec_info.ind_dst}), 16'h0003);
    fm_u.gap = 0;
    $display("test prefix done");
  endtask : t_prefix

  task automatic t_or();
    run(8'h00, 16'h9000, 1, 1, 4'h2, 4'h1);
    run(8'h00, 16'h9100, 1, 3, 4'h4, 4'h3);
    run(8'h00, 16'h9200, 1, 2, 4'h3, 4'h3);
    run(8'h00, 16'h9300, 1, 2, 4'h3, 4'h3);
    run(8'h00, enc(CLS_OR_IMM, 1'b0, 5'h12, 5'h12), 2, 1, 4'h3, 4'h1);
    run(8'h00, enc(CLS_OR_IMM, 1'b0, 5'h12, 5'h07), 2, 2, 4'h4, 4'h3);
    run(8'h00, enc(CLS_OR_IMM, 1'b0, 5'h12, 5'h0e), 2, 4, 4'h6, 4'h3);
    run(8'h00, enc(CLS_OR_GEN, 1'b0, 5'h12, 5'h12), 2, 0, 4'h2, 4'h1);
    run(8'h00, enc(CLS_OR_GEN, 1'b0, 5'h12, 5'h08), 2, 2, 4'h4, 4'h3);
    run(8'h00, enc(CLS_OR_GEN, 1'b0, 5'h0e, 5'h0e), 2, 6, 4'h8, 4'h4);
    $display("test or done");
  endtask : t_or

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge clock);
    chk(16'({fetch_ready, dec_valid, exec_busy}), 16'h0000);
    rst = 1'b0;
    @(negedge clock);
    chk(16'(fetch_ready), 16'h0001);
    t_plain();
    t_umul();
    t_long();
    t_prefix();
    t_or();
    stop_test();
  end
endmodule : mnnod_decoder_bench

/* File: mnnod_fetch_model.sv */
module mnnod_fetch_model (
  input  wire logic       clock,
  input  wire logic       fetch_ready,
  output logic            fetch_valid,
  output logic      [7:0] fetch_byte
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] queue_q[$];
  logic [7:0] last_r = 8'h00;
  int         gap    = 0;
  int         wait_n = 0;
  bit         took   = 1'b0;

  initial begin
    fetch_valid = 1'b0;
    fetch_byte  = 8'h00;
  end

  always @(posedge clock) begin
    took = fetch_valid && fetch_ready;
  end

  // an offer stays put until the edge that takes it
  always @(negedge clock) begin
    if (took) begin
      last_r = queue_q.pop_front();
      took   = 1'b0;
      wait_n = gap;
    end
    if (queue_q.size() != 0 && wait_n == 0) begin
      fetch_valid <= 1'b1;
      fetch_byte  <= queue_q[0];
    end else begin
      // idle bus never repeats the last byte
      fetch_valid <= 1'b0;
      fetch_byte  <= ~last_r;
      if (wait_n > 0) wait_n--;
    end
  end
endmodule : mnnod_fetch_model

/* File: mnnod_operand.sv */
module mnnod_operand (
  input  wire logic               [4:0] code,
  input  wire logic                     size,
  input  wire logic                     long_form,
  output mnnod_pkg::mnnod_opnd_type     opnd
);
  import mnnod_pkg::*;

  wire       is_reg  = code[4];
  wire       is_areg = code[4:1] == MODE_AREG;
  wire       is_ind  = code[4:1] == MODE_IND;
  wire       is_d8   = code[4:2] == MODE_D8;
  wire       is_d16  = code[4:2] == MODE_D16;
  wire       is_d24  = code[4:1] == MODE_D24;
  wire       is_a16  = code == MODE_ABS16;
  wire       is_a24  = code == MODE_ABS24;
  // 10 -> 0, 11 -> 1, 00 -> 2, 01 -> 3
  wire [1:0] widx    = {~code[1], code[0]};
  wire [3:0] byte_id = code[1] ? (code[0] ? REG_BYTE_L1 : REG_BYTE_L0)
                               : (code[0] ? REG_BYTE_H1 : REG_BYTE_H0);
  wire [3:0] reg_id  = is_areg   ? (code[0] ? REG_AREG1 : REG_AREG0)
                     : long_form ? (code[0] ? REG_PAIR31 : REG_PAIR20)
                     : size      ? (REG_WORD0 | {2'b00, widx})
                     : byte_id;

  assign opnd.kind   = is_reg ? K_REG : is_areg ? K_AREG : is_ind ? K_IND
                     : (is_a16 || is_a24) ? K_ABS : K_DSP;
  assign opnd.reg_id = reg_id;
  // dsp8/dsp16 carry the base in the low bits, others use an address register
  assign opnd.base   = (is_d8 || is_d16) ? code[1:0] : {1'b0, code[0]};
  assign opnd.nbytes = is_d8 ? NB_8 : (is_d16 || is_a16) ? NB_16
                     : (is_d24 || is_a24) ? NB_24 : 2'h0;
  assign opnd.mem    = !(is_reg || is_areg);
  // the long form has no 16-bit high-register pairs
  assign opnd.bad    = is_reg && ((code[3:2] != 2'b00) || (long_form && !code[1]));

endmodule : mnnod_operand

/* File: mnnod_pkg.sv */
package mnnod_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // indirect-addressing prefix bytes
  localparam logic [7:0] PFX_DST  = 8'h09;
  localparam logic [7:0] PFX_SRC  = 8'h41;
  localparam logic [7:0] PFX_BOTH = 8'h49;

  // class field, high nibble of the first opcode byte
  localparam logic [3:0] CLS_UMUL_IMM  = 4'h1;
  localparam logic [3:0] CLS_UMUL_GEN  = 4'h2;
  localparam logic [3:0] CLS_UMUL_LONG = 4'h3;
  localparam logic [3:0] CLS_NEGATE    = 4'h5;
  localparam logic [3:0] CLS_INVERT    = 4'h6;
  localparam logic [3:0] CLS_NOP       = 4'h7;
  localparam logic [3:0] CLS_OR_IMM    = 4'h8;
  localparam logic [3:0] CLS_OR_SHORT  = 4'h9;
  localparam logic [3:0] CLS_OR_GEN    = 4'ha;

  ////////////////////////////////////////////////////////////////////////////
  // 5-bit operand mode field
  localparam logic [4:0] MODE_REG0   = 5'h12;
  localparam logic [3:0] MODE_AREG   = 4'h1;
  localparam logic [3:0] MODE_IND    = 4'h0;
  localparam logic [2:0] MODE_D8     = 3'h1;
  localparam logic [2:0] MODE_D16    = 3'h2;
  localparam logic [3:0] MODE_D24    = 4'h6;
  localparam logic [4:0] MODE_ABS16  = 5'h0f;
  localparam logic [4:0] MODE_ABS24  = 5'h0e;
  localparam logic [4:0] MODE_SB_D8  = 5'h06;
  localparam logic [4:0] MODE_FB_D8  = 5'h07;

  // 2-bit short-form destination field
  localparam logic [1:0] SHORT_REG   = 2'h0;
  localparam logic [1:0] SHORT_ABS16 = 2'h1;
  localparam logic [1:0] SHORT_SB    = 2'h2;

  // register identities
  localparam logic [3:0] REG_BYTE_L0 = 4'h0;
  localparam logic [3:0] REG_BYTE_L1 = 4'h1;
  localparam logic [3:0] REG_BYTE_H0 = 4'h2;
  localparam logic [3:0] REG_BYTE_H1 = 4'h3;
  localparam logic [3:0] REG_WORD0   = 4'h4;
  localparam logic [3:0] REG_PAIR20  = 4'h8;
  localparam logic [3:0] REG_PAIR31  = 4'h9;
  localparam logic [3:0] REG_AREG0   = 4'ha;
  localparam logic [3:0] REG_AREG1   = 4'hb;

  ////////////////////////////////////////////////////////////////////////////
  // byte counts
  localparam logic [1:0] NB_8       = 2'h1;
  localparam logic [1:0] NB_16      = 2'h2;
  localparam logic [1:0] NB_24      = 2'h3;
  localparam logic [1:0] OPB_ONE    = 2'h1;
  localparam logic [1:0] OPB_TWO    = 2'h2;
  localparam logic [1:0] OPB_LONG   = 2'h3;
  localparam logic [1:0] IMM_BYTE   = 2'h1;
  localparam logic [1:0] IMM_WORD   = 2'h2;
  localparam logic [3:0] LEN_PREFIX = 4'h1;

  // cycle counts
  localparam logic [3:0] CYC_UMUL_RR  = 4'h3;
  localparam logic [3:0] CYC_UMUL_RM  = 4'h5;
  localparam logic [3:0] CYC_UMUL_MM  = 4'h6;
  localparam logic [3:0] CYC_LONG_R   = 4'h8;
  localparam logic [3:0] CYC_LONG_M   = 4'h9;
  localparam logic [3:0] CYC_OR_RR    = 4'h1;
  localparam logic [3:0] CYC_OR_RM    = 4'h3;
  localparam logic [3:0] CYC_OR_MM    = 4'h4;
  localparam logic [3:0] CYC_UN_R     = 4'h1;
  localparam logic [3:0] CYC_UN_M     = 4'h3;
  localparam logic [3:0] CYC_NOP      = 4'h1;
  localparam logic [3:0] CYC_ILLEGAL  = 4'h1;
  localparam logic [3:0] CYC_IND_ONE  = 4'h3;
  localparam logic [3:0] CYC_IND_BOTH = 4'h6;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {K_REG, K_AREG, K_IND, K_DSP, K_ABS} mnnod_kind_type;

  typedef enum logic [4:0] {
    S_OP   = 5'b00001,
    S_OP1  = 5'b00010,
    S_OP2  = 5'b00100,
    S_EXT  = 5'b01000,
    S_EXEC = 5'b10000
  } mnnod_state_type;

  typedef struct packed {
    mnnod_kind_type kind;
    logic [3:0]     reg_id;
    logic [1:0]     base;
    logic [1:0]     nbytes;
    logic           mem;
    logic           bad;
  } mnnod_opnd_type;

  typedef struct packed {
    logic [3:0]     cls;
    logic           size;
    logic [4:0]     src_code;
    logic [4:0]     dst_code;
    mnnod_opnd_type src;
    mnnod_opnd_type dst;
    logic           ind_src;
    logic           ind_dst;
    logic [3:0]     base_len;
    logic [3:0]     base_cyc;
    logic [3:0]     len;
    logic [3:0]     cyc;
    logic           illegal;
  } mnnod_info_type;

endpackage : mnnod_pkg

/* File: mnnod_timer.sv */
module mnnod_timer #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  busy,
  output logic                  done
);

  logic [WIDTH-1:0] cnt_r;

  // busy stays high for exactly count cycles after the load edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      busy  <= 1'b0;
    end else if (load) begin
      cnt_r <= count;
      busy  <= 1'b1;
    end else begin
      cnt_r <= (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
      busy  <= cnt_r > 1;
    end
  end

  assign done = busy && (cnt_r == 1);

endmodule : mnnod_timer
